// ### inc/dac_load_pkg.sv
// constants shared by the quad converter load control and its bench
package dac_load_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int ADDR_W = 2;
    localparam int NUM_CH = 4;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 14;
    localparam int FULL_SCALE_STEPS = 4096;
    localparam logic [11:0] ZERO_CODE = 12'h000;
    localparam logic [11:0] MID_CODE = 12'h800;
    localparam logic [11:0] CODE_RST = 12'h000;
    localparam logic [15:0] SHIFT_RST = 16'h0000;
    localparam int UPD_W = 48;
    localparam int FIFO_DEPTH = 8;
    // pin vector positions
    localparam int PIN_N = 7;
    localparam int PIN_DIN = 0;
    localparam int PIN_CLK = 1;
    localparam int PIN_CS = 2;
    localparam int PIN_LR = 3;
    localparam int PIN_LD = 4;
    localparam int PIN_RST = 5;
    localparam int PIN_SEL = 6;
    // idle levels: strobes, select and reset pin released
    localparam logic [6:0] PIN_IDLE = 7'h3E;
    // host-side timing, kept for the bench
    localparam int T_CLK_NS = 10;
    localparam int T_LD1_NS = 40;
    localparam int T_LD2_NS = 15;
    localparam int T_LDRW_NS = 45;
    localparam int T_RSSH_NS = 25;
    localparam int T_RSTW_NS = 70;
    localparam int LD1_CYC = (T_LD1_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int LD2_CYC = (T_LD2_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int LDRW_CYC = (T_LDRW_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int RSSH_CYC = (T_RSSH_NS + T_CLK_NS - 1) / T_CLK_NS;
    localparam int RSTW_CYC = (T_RSTW_NS + T_CLK_NS - 1) / T_CLK_NS;
endpackage

// ### inc/stream_if.sv
// valid/ready word channel between the load control and its buffer
`timescale 1ns/100ps
interface stream_if #(parameter int W = 48);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

// ### hw/upd_fifo.sv
// small word FIFO with a registered read stage
`timescale 1ns/100ps
module upd_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    stream_if.snk wr, // filling side
    stream_if.src rd // draining side
);
    // pointers wrap naturally, so depth must be a power of two
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic do_wr, do_rd;

    assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
    assign rd.valid = ov_q;
    assign rd.data = od_q;

    always_comb begin
        do_wr = wr.valid & wr.ready;
        do_rd = (cnt_q != '0) & (~ov_q | rd.ready);
        wp_d = do_wr ? wp_q + 1'b1 : wp_q;
        rp_d = do_rd ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q;
        if (do_wr && !do_rd) begin
            cnt_d = cnt_q + 1'b1;
        end else if (!do_wr && do_rd) begin
            cnt_d = cnt_q - 1'b1;
        end
        ov_d = do_rd ? 1'b1 : (rd.ready ? 1'b0 : ov_q);
        od_d = do_rd ? mem[rp_q] : od_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ov_q <= ov_d;
            od_q <= od_d;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_q] <= wr.data;
        end
    end
endmodule

// ### hw/quad_dac_serial_load_control.sv
// serial load, input and converter registers of a quad 12-bit converter
`timescale 1ns/100ps
module quad_dac_serial_load_control
    import dac_load_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk, // 100 MHz system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic serial_in_line, // serial data pin
    input wire logic serial_clk, // serial clock pin
    input wire logic chip_sel_n, // chip select pin, low
    input wire logic input_latch_strobe_n, // input register load, low
    input wire logic output_latch_strobe_n, // converter update, low
    input wire logic reset_pin_n, // code reset pin, low
    input wire logic reset_code_choice, // 0 zero scale, 1 mid scale
    output logic [3:0][11:0] conv_code, // converter codes, D..A
    output logic upd_valid, // snapshot word available
    output logic [47:0] upd_data, // converter codes snapshot
    input wire logic upd_ready // consumer takes snapshot
);
    logic [PIN_N-1:0] pins_raw, meta_q, sync_q;
    logic ser_bit, shift_clk, shift_clk_q, rise;
    logic lr_low, ld_low, pin_rst;
    logic [11:0] rst_code, code;
    logic [ADDR_W-1:0] sel;
    logic [WORD_BITS-1:0] shift_q, shift_d;
    logic [NUM_CH-1:0][CODE_BITS-1:0] in_q, in_d, conv_q, conv_d, tgt;
    logic push_valid;

    stream_if #(.W(UPD_W)) push_if();
    stream_if #(.W(UPD_W)) pop_if();

    assign pins_raw = {reset_code_choice, reset_pin_n, output_latch_strobe_n,
                       input_latch_strobe_n, chip_sel_n, serial_clk,
                       serial_in_line};

    // two-flop synchronisers; the first stage feeds only the second
    for (genvar p = 0; p < PIN_N; p++) begin : g_sync
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                meta_q[p] <= PIN_IDLE[p];
                sync_q[p] <= PIN_IDLE[p];
            end else begin
                meta_q[p] <= pins_raw[p];
                sync_q[p] <= meta_q[p];
            end
        end
    end

    assign ser_bit = sync_q[PIN_DIN];
    assign shift_clk = sync_q[PIN_CLK] | sync_q[PIN_CS];
    assign rise = shift_clk & ~shift_clk_q;
    assign lr_low = ~sync_q[PIN_LR];
    assign ld_low = ~sync_q[PIN_LD];
    assign pin_rst = ~sync_q[PIN_RST];
    assign rst_code = sync_q[PIN_SEL] ? MID_CODE : ZERO_CODE;
    assign sel = shift_q[ADDR_MSB:ADDR_LSB];
    // bits 13:12 are the unused pair and are simply never read
    assign code = shift_q[CODE_BITS-1:0];

    // shift stage; the reset pin has no say here
    always_comb begin
        shift_d = shift_q;
        if (rise) begin
            shift_d = {shift_q[WORD_BITS-2:0], ser_bit};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_q <= SHIFT_RST;
            shift_clk_q <= 1'b1;
        end else begin
            shift_q <= shift_d;
            shift_clk_q <= shift_clk;
        end
    end

    // per-channel input register and converter target
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        always_comb begin
            in_d[i] = in_q[i];
            if (pin_rst) begin
                in_d[i] = rst_code;
            end else if (lr_low && sel == ADDR_W'(i)) begin
                in_d[i] = code;
            end
            // while latched after reset the code just stays put
            tgt[i] = conv_q[i];
            if (pin_rst) begin
                tgt[i] = rst_code;
            end else if (ld_low) begin
                tgt[i] = in_q[i];
            end
        end
    end

    // a full buffer holds all outputs back together rather than tear them;
    // reset overrides the stall and may drop its snapshot
    always_comb begin
        push_valid = (tgt != conv_q);
        conv_d = conv_q;
        if (pin_rst || push_if.ready) begin
            conv_d = tgt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_q <= {NUM_CH{CODE_RST}};
            conv_q <= {NUM_CH{CODE_RST}};
        end else begin
            in_q <= in_d;
            conv_q <= conv_d;
        end
    end

    assign push_if.valid = push_valid;
    assign push_if.data = tgt;
    assign pop_if.ready = upd_ready;
    assign upd_valid = pop_if.valid;
    assign upd_data = pop_if.data;
    // straight binary, one step is full scale over 4096
    assign conv_code = conv_q;

    upd_fifo #(
        .WIDTH(UPD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr(push_if),
        .rd(pop_if)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_rst_release;
        pin_rst ##1 (!pin_rst && !lr_low);
    endsequence

    sequence s_load_window;
        !pin_rst && lr_low;
    endsequence

    property p_shift_adv;
        rise |=> shift_q == {$past(shift_q[14:0]), $past(ser_bit)};
    endproperty
    a_shift_adv: assert property (p_shift_adv)
        else $error("shift register did not advance on edge");

    property p_shift_hold;
        !rise |=> $stable(shift_q);
    endproperty
    a_shift_hold: assert property (p_shift_hold)
        else $error("shift register moved without an edge");

    property p_rst_keeps_shift;
        (pin_rst && !rise) [*2] |=> $stable(shift_q);
    endproperty
    a_rst_keeps_shift: assert property (p_rst_keeps_shift)
        else $error("reset pin disturbed shift register");

    property p_load_sel;
        s_load_window |=> in_q[$past(sel)] == $past(code);
    endproperty
    a_load_sel: assert property (p_load_sel)
        else $error("addressed input register missed the code");

    property p_other_hold;
        s_load_window and (sel != 2'b00) |=> $stable(in_q[0]);
    endproperty
    a_other_hold: assert property (p_other_hold)
        else $error("unaddressed input register changed");

    property p_map_d;
        s_load_window and (shift_q[15:14] == 2'b11) |=>
            in_q[3] == $past(shift_q[11:0]);
    endproperty
    a_map_d: assert property (p_map_d)
        else $error("address 11 did not load channel D");

    property p_latch_hold;
        !pin_rst && !lr_low |=> $stable(in_q);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("input registers moved while latched");

    property p_rst_force;
        pin_rst |=> in_q == {NUM_CH{$past(rst_code)}} &&
                    conv_q == {NUM_CH{$past(rst_code)}};
    endproperty
    a_rst_force: assert property (p_rst_force)
        else $error("reset code not forced into registers");

    property p_rst_release;
        s_rst_release |=> $stable(in_q) ##1 $stable(in_q);
    endproperty
    a_rst_release: assert property (p_rst_release)
        else $error("latched register lost reset code");

    property p_conv_follow;
        !pin_rst && ld_low && push_if.ready |=> conv_q == $past(in_q);
    endproperty
    a_conv_follow: assert property (p_conv_follow)
        else $error("converter registers did not follow inputs");

    property p_conv_hold;
        !pin_rst && !ld_low |=> $stable(conv_q);
    endproperty
    a_conv_hold: assert property (p_conv_hold)
        else $error("converter registers moved while latched");
endmodule

// ### sim/host_model.sv
// host controller model driving the converter's serial and strobe pins
`timescale 1ns/100ps
module host_model (
    input logic clk, // bench clock, only to place pin changes
    output logic serial_in_line, // serial data pin
    output logic serial_clk, // serial clock pin
    output logic chip_sel_n, // chip select, low
    output logic input_latch_strobe_n, // input load, low
    output logic output_latch_strobe_n, // converter update, low
    output logic reset_pin_n, // code reset, low
    output logic reset_code_choice // reset code pick
);
    initial begin
        {serial_in_line, serial_clk, chip_sel_n} = 3'b011;
        {input_latch_strobe_n, output_latch_strobe_n} = 2'b11;
        {reset_pin_n, reset_code_choice} = 2'b10;
    end
    // msb first; one line toggles, the other is held low for the frame
    task automatic send_bits(input logic [19:0] bits, input int n,
                             input bit via_cs);
        // pins move 1 ns after an edge, never racing the sampling flops
        @(posedge clk);
        #1;
        if (via_cs) serial_clk = 1'b0;
        else chip_sel_n = 1'b0;
        #20;
        for (int i = n - 1; i >= 0; i--) begin
            if (via_cs) chip_sel_n = 1'b0;
            else serial_clk = 1'b0;
            serial_in_line = bits[i];
            #50;
            if (via_cs) chip_sel_n = 1'b1;
            else serial_clk = 1'b1;
            #30;
        end
        // the held line rises with the toggling one high, so no stray shift
        chip_sel_n = 1'b1;
        serial_clk = 1'b1;
        // line released: never leave the last bit looking valid
        serial_in_line = ~serial_in_line;
    endtask
    // no shifting while low; setup before the next frame kept
    task automatic load_input();
        @(posedge clk);
        #1;
        #20;
        input_latch_strobe_n = 1'b0;
        #60;
        input_latch_strobe_n = 1'b1;
        #50;
    endtask
    task automatic pulse_update();
        @(posedge clk);
        #1;
        output_latch_strobe_n = 1'b0;
        #60;
        output_latch_strobe_n = 1'b1;
        #30;
    endtask
    task automatic reset_codes(input logic choice);
        @(posedge clk);
        #1;
        reset_code_choice = choice;
        #30;
        reset_pin_n = 1'b0;
        #80;
        reset_pin_n = 1'b1;
        #30;
    endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the quad converter load control
`timescale 1ns/100ps
module tb;
    import dac_load_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic upd_ready = 1'b0;
    logic din, sclk, cs_n, ld_n, upd_n, rp_n, pick, upd_valid;
    logic [3:0][11:0] conv_code, exp_in, exp_conv;
    logic [47:0] upd_data;
    logic [47:0] exp_q[$];
    int mode = 0;
    int err_total = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    host_model u_host (.clk(clk), .serial_in_line(din), .serial_clk(sclk),
        .chip_sel_n(cs_n), .input_latch_strobe_n(ld_n),
        .output_latch_strobe_n(upd_n), .reset_pin_n(rp_n),
        .reset_code_choice(pick));
    quad_dac_serial_load_control #(.DEPTH(FIFO_DEPTH)) uut (.clk(clk),
        .sys_rst(sys_rst), .serial_in_line(din), .serial_clk(sclk),
        .chip_sel_n(cs_n), .input_latch_strobe_n(ld_n),
        .output_latch_strobe_n(upd_n), .reset_pin_n(rp_n),
        .reset_code_choice(pick), .conv_code(conv_code),
        .upd_valid(upd_valid), .upd_data(upd_data), .upd_ready(upd_ready));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // mode 1 stalls the consumer to fill the buffer
    always @(posedge clk) begin
        #1 upd_ready <= (mode == 1) ? 1'b0 : 1'($urandom % 3 != 0);
    end
    always @(posedge clk) begin
        if (!sys_rst && upd_valid === 1'b1 && upd_ready === 1'b1) begin
            if (exp_q.size() > 0)
                chk(upd_data, exp_q.pop_front());
            else begin
                err_total++;
                $display("Error %0t: unexpected snapshot", $time);
            end
        end
    end
    task automatic put(input logic [1:0] a, input logic [11:0] code,
                       input bit via_cs, input logic [3:0] junk, input int n);
        u_host.send_bits({junk, a, junk[1:0], code}, n, via_cs);
        u_host.load_input();
        exp_in[a] = code;
        repeat (4) @(posedge clk);
        chk(conv_code, exp_conv);
    endtask
    task automatic upd();
        if (exp_in !== exp_conv) exp_q.push_back(exp_in);
        exp_conv = exp_in;
        u_host.pulse_update();
        repeat (4) @(posedge clk);
        chk(conv_code, exp_conv);
    endtask
    task automatic rst_pin(input logic ch);
        exp_in = {4{ch, 11'h000}};
        if (exp_in !== exp_conv) exp_q.push_back(exp_in);
        exp_conv = exp_in;
        u_host.reset_codes(ch);
        repeat (4) @(posedge clk);
        chk(conv_code, exp_conv);
    endtask
    task automatic drain(input int hold);
        int i;
        repeat (hold) @(posedge clk);
        for (i = 0; i < 500 && (upd_valid !== 1'b0 || exp_q.size()); i++)
            @(posedge clk);
        if (i == 500) begin
            err_total++;
            $display("Error %0t: drain timed out", $time);
            results();
        end
    endtask
    initial begin
        exp_in = '0;
        exp_conv = '0;
        void'($urandom(51599));
        repeat (20) @(posedge clk);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clk);
        chk(conv_code, '0);
        for (int i = 0; i < 8; i++) begin
            put(2'(i), (i == 5) ? 12'hFFF : 12'($urandom), i[2], 4'h0, 16);
            if (i[0]) upd();
        end
        put(2'b10, 12'hA5C, 1'b0, 4'hF, 20);
        upd();
        rst_pin(1'b1);
        u_host.load_input();
        exp_in[2] = 12'hA5C;
        upd();
        rst_pin(1'b0);
        drain(0);
        mode = 1;
        // nonzero distinct codes, so every pulse wants a snapshot
        for (int i = 0; i < 12; i++) begin
            exp_in[0] = {4'(i + 1), 8'($urandom)};
            u_host.send_bits({8'h00, exp_in[0]}, 16, 1'b0);
            u_host.load_input();
            u_host.pulse_update();
            // output stage plus memory hold depth + 1; later pulses stall
            if (i < FIFO_DEPTH + 1) begin
                exp_q.push_back(exp_in);
                exp_conv = exp_in;
            end
        end
        chk(conv_code, exp_conv);
        chk({47'h0, upd_valid}, 48'h1);
        mode = 2;
        drain(50);
        chk(conv_code, exp_conv);
        mode = 0;
        put(2'b11, 12'h001, 1'b1, 4'h0, 16);
        upd();
        drain(0);
        results();
    end
endmodule
